// >>> design/sbw_pkg.sv
// Shared constants for the break, wake and synchronous host serial port
package sbw_pkg;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_TXDATA = 8'h03;
  localparam logic [7:0] REG_RXDATA = 8'h04;
  localparam logic [7:0] REG_BAUD_LO = 8'h05;
  localparam logic [7:0] REG_BAUD_HI = 8'h06;
  // Control register fields
  localparam int CTRL_PORT_EN = 0;
  localparam int CTRL_SYNC = 1;
  localparam int CTRL_HOST_CLK = 2;
  localparam int CTRL_TX_EN = 3;
  localparam int CTRL_SEND_BRK = 4;
  localparam int CTRL_SINGLE_RX = 5;
  localparam int CTRL_CONT_RX = 6;
  // Mode register fields
  localparam int MODE_CLK_POL = 0;
  localparam int MODE_WAKE = 1;
  // Status register fields
  localparam int STAT_SHIFT_EMPTY = 0;
  localparam int STAT_TX_BUF_EMPTY = 1;
  localparam int STAT_RX_PENDING = 2;
  localparam int STAT_FRAME_ERR = 3;
  localparam int STAT_RX_IDLE = 4;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  // Frame lengths in bit times
  localparam logic [3:0] ASYNC_BITS = 4'ha;
  localparam logic [3:0] BREAK_BITS = 4'he;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [11:0] BREAK_ZEROS = 12'h000;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  typedef enum logic {TX_IDLE, TX_SHIFT} sbw_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sbw_rx_state_t;
endpackage

// >>> design/sbw_baud_if.sv
// Carrier between the port core and its bit-rate tick generator
`timescale 1ns/100ps
interface sbw_baud_if;
  logic [15:0] divisor;
  logic restart;
  logic tick;
  modport core (output divisor, output restart, input tick);
  modport gen (input divisor, input restart, output tick);
endinterface

// >>> design/sbw_baud_gen.sv
// Bit-rate tick generator: one tick every divisor+1 system clocks
`timescale 1ns/100ps
module sbw_baud_gen (
  input wire logic clk_sys,
  input wire logic rst_n,
  sbw_baud_if.gen bus
);
  logic [15:0] count;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
    end else if (bus.restart || count == bus.divisor) begin
      count <= 16'h0000;
    end else begin
      count <= count + 16'h0001;
    end
  end

  // Restart swallows the tick so a new frame gets a full first bit
  assign bus.tick = !bus.restart && (count == bus.divisor);
endmodule

// >>> design/sbw_rx_filter.sv
// Three-stage synchroniser and agreement filter for the receive pin
`timescale 1ns/100ps
module sbw_rx_filter (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pinIn,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      level <= 1'b1;
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
      // Change is taken only once the last two stages agree
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule

// >>> design/sbw_core.sv
// Serial port core: wake on edge, break send and detect, synchronous host transmit
// How it works
// - Wake edge sets the receive pending flag
// - Rising receive edge clears wake enable
// - Reading receive data clears pending flag
// - Break is start, twelve zeros, stop
// - Send-break write starts break, data ignored
// - Send-break bit clears after break stop
// - Byte queued during break follows it
// - Shift-empty flag tracks breaks like characters
// - Buffer empty flag permits next write
// - Received break: pending, framing error, 00h
// - Wake watches two edges, then receives byte
// - Synchronous mode: no start or stop bits
// - Host mode needs sync, host clock, enable
// - Host transmit only with both receive enables clear
// - Host drives the clock pin
// - One clock per data bit, no more
// - Data changes on leading clock edge
// - Polarity sets clock idle level and edge
// - Host transmit drives data and clock pins
// - Holding byte moves to idle shifter at once
`timescale 1ns/100ps
module sbw_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic rxDataIn,
  output logic rxDataOut,
  output logic rxDataOe,
  output logic serialClockOut,
  output logic serialClockOe
);
  sbw_baud_if baudBus();
  sbw_pkg::sbw_tx_state_t txState;
  sbw_pkg::sbw_rx_state_t rxState;

  logic rxLine;
  logic rxPrev;
  logic portEnable;
  logic syncMode;
  logic hostClockSource;
  logic transmitEnable;
  logic sendBreak;
  logic singleRxEnable;
  logic contRxEnable;
  logic clockIdlePolarity;
  logic wakeOnEdge;
  logic [15:0] baudDiv;
  logic [7:0] holdData;
  logic holdFull;
  logic holdBreak;
  logic breakInFlight;
  logic [13:0] frame;
  logic [3:0] bitsLeft;
  logic frameBreak;
  logic txLine;
  logic ckActive;
  logic [15:0] rxCnt;
  logic [2:0] rxBits;
  logic [7:0] rxShift;
  logic [7:0] rxData;
  logic framingError;
  logic rxPending;

  sbw_baud_gen uBaud (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus(baudBus)
  );

  sbw_rx_filter uRxFilter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(rxDataIn),
    .level(rxLine)
  );

  logic wrCtrl;
  logic wrMode;
  logic wrTx;
  logic rdRx;
  logic rxFall;
  logic rxRise;
  logic syncHost;
  logic syncHostTx;
  logic txAllowed;
  logic txAccept;
  logic breakReq;
  logic load;
  logic tick;
  logic lastTick;
  logic breakDone;
  logic syncDone;
  logic wakeEv;
  logic rxDone;
  logic rxSet;
  logic rxEnable;

  assign wrCtrl = regWrite && regAddr == sbw_pkg::REG_CTRL;
  assign wrMode = regWrite && regAddr == sbw_pkg::REG_MODE;
  assign wrTx = regWrite && regAddr == sbw_pkg::REG_TXDATA;
  assign rdRx = regRead && regAddr == sbw_pkg::REG_RXDATA;
  assign rxFall = rxPrev && !rxLine;
  assign rxRise = !rxPrev && rxLine;
  assign syncHost = portEnable && syncMode && hostClockSource;
  assign syncHostTx = syncHost && !singleRxEnable && !contRxEnable;
  assign txAllowed = portEnable && transmitEnable && (!syncMode || syncHostTx);
  assign txAccept = wrTx && portEnable && transmitEnable && !holdFull;
  // Breaks are an asynchronous feature only
  assign breakReq = sendBreak && !breakInFlight && !syncMode;
  assign load = txState == sbw_pkg::TX_IDLE && holdFull && txAllowed;
  assign tick = baudBus.tick;
  assign lastTick = txState == sbw_pkg::TX_SHIFT && tick && bitsLeft == 4'h1
    && !(syncMode && ckActive);
  assign breakDone = lastTick && frameBreak;
  assign syncDone = lastTick && syncMode;
  assign wakeEv = portEnable && !syncMode && wakeOnEdge && rxFall;
  assign rxDone = rxState == sbw_pkg::RX_STOP && rxCnt == baudDiv;
  assign rxSet = wakeEv || rxDone;
  // Normal reception is parked while waiting for the wake edge
  assign rxEnable = portEnable && !syncMode && contRxEnable && !wakeOnEdge;
  assign baudBus.divisor = baudDiv;
  assign baudBus.restart = load;

  // Control registers; a software write wins over a hardware clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {contRxEnable, singleRxEnable, sendBreak, transmitEnable} <= 4'h0;
      {hostClockSource, syncMode, portEnable} <= 3'h0;
    end else if (wrCtrl) begin
      portEnable <= regWrData[sbw_pkg::CTRL_PORT_EN];
      syncMode <= regWrData[sbw_pkg::CTRL_SYNC];
      hostClockSource <= regWrData[sbw_pkg::CTRL_HOST_CLK];
      transmitEnable <= regWrData[sbw_pkg::CTRL_TX_EN];
      sendBreak <= regWrData[sbw_pkg::CTRL_SEND_BRK];
      singleRxEnable <= regWrData[sbw_pkg::CTRL_SINGLE_RX];
      contRxEnable <= regWrData[sbw_pkg::CTRL_CONT_RX];
    end else if (breakDone) begin
      sendBreak <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clockIdlePolarity <= 1'b0;
      wakeOnEdge <= 1'b0;
    end else if (wrMode) begin
      clockIdlePolarity <= regWrData[sbw_pkg::MODE_CLK_POL];
      wakeOnEdge <= regWrData[sbw_pkg::MODE_WAKE];
    end else if (wakeOnEdge && rxRise) begin
      wakeOnEdge <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      baudDiv <= sbw_pkg::BAUD_RESET;
    end else if (regWrite && regAddr == sbw_pkg::REG_BAUD_LO) begin
      baudDiv[7:0] <= regWrData;
    end else if (regWrite && regAddr == sbw_pkg::REG_BAUD_HI) begin
      baudDiv[15:8] <= regWrData;
    end
  end

  // Holding register; a write while full is dropped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      holdFull <= 1'b0;
      holdData <= 8'h00;
      holdBreak <= 1'b0;
    end else if (!portEnable) begin
      holdFull <= 1'b0;
    end else if (txAccept) begin
      holdFull <= 1'b1;
      holdData <= regWrData;
      holdBreak <= breakReq;
    end else if (load) begin
      holdFull <= 1'b0;
    end
  end

  // Later writes during a break are ordinary characters
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      breakInFlight <= 1'b0;
    end else if (!portEnable || breakDone) begin
      breakInFlight <= 1'b0;
    end else if (txAccept && breakReq) begin
      breakInFlight <= 1'b1;
    end
  end

  // Shifter, not visible to software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txState <= sbw_pkg::TX_IDLE;
      frame <= 14'h3fff;
      bitsLeft <= 4'h0;
      frameBreak <= 1'b0;
      txLine <= 1'b1;
      ckActive <= 1'b0;
    end else if (!portEnable) begin
      txState <= sbw_pkg::TX_IDLE;
      txLine <= 1'b1;
      ckActive <= 1'b0;
    end else begin
      case (txState)
        sbw_pkg::TX_IDLE: begin
          if (load) begin
            txState <= sbw_pkg::TX_SHIFT;
            frameBreak <= holdBreak && !syncMode;
            if (syncMode) begin
              frame <= {6'h00, holdData};
              bitsLeft <= sbw_pkg::SYNC_BITS;
              txLine <= holdData[0];
              ckActive <= 1'b1;
            end else if (holdBreak) begin
              frame <= {1'b1, sbw_pkg::BREAK_ZEROS, 1'b0};
              bitsLeft <= sbw_pkg::BREAK_BITS;
              txLine <= 1'b0;
            end else begin
              frame <= {4'hf, 1'b1, holdData, 1'b0};
              bitsLeft <= sbw_pkg::ASYNC_BITS;
              txLine <= 1'b0;
            end
          end
        end
        sbw_pkg::TX_SHIFT: begin
          if (tick) begin
            if (syncMode && ckActive) begin
              ckActive <= 1'b0;
            end else if (bitsLeft == 4'h1) begin
              txState <= sbw_pkg::TX_IDLE;
              txLine <= 1'b1;
            end else begin
              frame <= frame >> 1;
              txLine <= frame[1];
              bitsLeft <= bitsLeft - 4'h1;
              ckActive <= syncMode;
            end
          end
        end
        default: begin
          txState <= sbw_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Asynchronous receiver, sampled at mid bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxState <= sbw_pkg::RX_IDLE;
      rxCnt <= 16'h0000;
      rxBits <= 3'h0;
      rxShift <= 8'h00;
      rxData <= 8'h00;
      framingError <= 1'b0;
    end else if (!rxEnable) begin
      rxState <= sbw_pkg::RX_IDLE;
    end else begin
      case (rxState)
        sbw_pkg::RX_IDLE: begin
          if (rxFall) begin
            rxState <= sbw_pkg::RX_START;
            rxCnt <= 16'h0000;
          end
        end
        sbw_pkg::RX_START: begin
          if (rxCnt == (baudDiv >> 1)) begin
            rxCnt <= 16'h0000;
            rxBits <= 3'h0;
            rxState <= rxLine ? sbw_pkg::RX_IDLE : sbw_pkg::RX_DATA;
          end else begin
            rxCnt <= rxCnt + 16'h0001;
          end
        end
        sbw_pkg::RX_DATA: begin
          if (rxCnt == baudDiv) begin
            rxCnt <= 16'h0000;
            rxShift <= {rxLine, rxShift[7:1]};
            rxBits <= rxBits + 3'h1;
            if (rxBits == sbw_pkg::LAST_DATA_BIT) begin
              rxState <= sbw_pkg::RX_STOP;
            end
          end else begin
            rxCnt <= rxCnt + 16'h0001;
          end
        end
        sbw_pkg::RX_STOP: begin
          if (rxDone) begin
            rxData <= rxShift;
            framingError <= !rxLine;
            rxState <= sbw_pkg::RX_IDLE;
          end else begin
            rxCnt <= rxCnt + 16'h0001;
          end
        end
        default: begin
          rxState <= sbw_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Pending flag: a new event beats a read in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxPending <= 1'b0;
      rxPrev <= 1'b1;
    end else begin
      rxPrev <= rxLine;
      if (!portEnable) begin
        rxPending <= 1'b0;
      end else if (rxSet) begin
        rxPending <= 1'b1;
      end else if (rdRx) begin
        rxPending <= 1'b0;
      end
    end
  end

  // Read data stands in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (!regRead) begin
      regRdData <= 8'h00;
    end else if (regAddr == sbw_pkg::REG_CTRL) begin
      regRdData <= {1'b0, contRxEnable, singleRxEnable, sendBreak, transmitEnable,
        hostClockSource, syncMode, portEnable};
    end else if (regAddr == sbw_pkg::REG_MODE) begin
      regRdData <= {6'h00, wakeOnEdge, clockIdlePolarity};
    end else if (regAddr == sbw_pkg::REG_STATUS) begin
      regRdData <= {3'h0, rxState == sbw_pkg::RX_IDLE && !wakeOnEdge, framingError,
        rxPending, !holdFull, txState == sbw_pkg::TX_IDLE};
    end else if (regAddr == sbw_pkg::REG_RXDATA) begin
      regRdData <= rxData;
    end else if (regAddr == sbw_pkg::REG_BAUD_LO) begin
      regRdData <= baudDiv[7:0];
    end else if (regAddr == sbw_pkg::REG_BAUD_HI) begin
      regRdData <= baudDiv[15:8];
    end else begin
      regRdData <= 8'h00;
    end
  end

  // Pins: in asynchronous mode the clock pin carries the transmit line
  assign serialClockOut = syncHost ? (clockIdlePolarity ^ ckActive) : txLine;
  assign serialClockOe = syncHost || (portEnable && !syncMode);
  assign rxDataOut = txLine;
  assign rxDataOe = syncHostTx;

  // Checking helpers
  logic ckPrev;
  logic [3:0] leadCount;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ckPrev <= 1'b0;
      leadCount <= 4'h0;
    end else begin
      ckPrev <= ckActive;
      if (load) begin
        leadCount <= 4'h0;
      end else if (ckActive && !ckPrev) begin
        leadCount <= leadCount + 4'h1;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  wake_pend_a: assert property (wakeEv |=> rxPending)
    else $error("wake edge did not set pending");
  wue_clear_a: assert property (wakeOnEdge && rxRise && !wrMode |=> !wakeOnEdge)
    else $error("wake enable not cleared by rising edge");
  read_clear_a: assert property (rdRx && !rxSet && portEnable |=> !rxPending)
    else $error("data read did not clear pending");
  break_zero_a: assert property (txState == sbw_pkg::TX_SHIFT && frameBreak
    && bitsLeft > 4'h1 |-> !txLine)
    else $error("break sent a one before its stop bit");
  send_break_request_clear_a: assert property (breakDone && !wrCtrl |=> !sendBreak)
    else $error("send break not cleared after stop bit");
  queue_after_a: assert property (breakDone && holdFull && !wrCtrl
    |=> ##1 txState == sbw_pkg::TX_SHIFT && !frameBreak)
    else $error("queued byte did not follow the break");
  shift_reg_empty_busy_a: assert property (load |=> txState != sbw_pkg::TX_IDLE [*2])
    else $error("shift empty during active frame");
  tbe_full_a: assert property (txAccept |=> holdFull)
    else $error("buffer empty after accepted write");
  brk_rx_a: assert property (rxDone && rxShift == 8'h00 && !rxLine
    |=> rxPending && framingError && rxData == 8'h00)
    else $error("received break not reported");
  sync_clocks_a: assert property (syncDone |-> leadCount == 4'h8)
    else $error("wrong number of shift clocks");
  idle_pol_a: assert property (syncHost && txState == sbw_pkg::TX_IDLE
    |-> serialClockOut == clockIdlePolarity)
    else $error("clock not at idle level");
  drive_a: assert property (syncHostTx |-> rxDataOe && serialClockOe)
    else $error("host transmit pins not driven");

  break_seen_c: cover property (breakDone ##[1:300] syncDone || breakDone);
  wake_seen_c: cover property (wakeEv ##[1:1000] rxRise);
  rx_break_c: cover property (rxDone && !rxLine);
  sync_frame_c: cover property (syncDone);
endmodule

// >>> dv/sbw_peer.sv
// Serial bus peer: drives the data pin, decodes async, break and sync frames
`timescale 1ns/100ps
module sbw_peer #(
  parameter int BIT = 8
) (
  input wire logic clk_sys,
  input wire logic dataLine,
  input wire logic txLine,
  input wire logic syncMode,
  input wire logic polarity,
  output logic peerLow,
  output logic gotToggle,
  output logic [11:0] gotValue,
  output int syncBits
);
  logic [9:0] bits;
  logic [7:0] shiftIn;
  logic prevClk;
  int n;

  initial begin
    peerLow = 1'b0;
    gotToggle = 1'b0;
    gotValue = 12'h000;
    syncBits = 0;
    prevClk = 1'b1;
  end

  task automatic report(input logic [11:0] v);
    gotValue = v;
    gotToggle = ~gotToggle;
  endtask

  task automatic drive(input logic low);
    peerLow <= low;
  endtask

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      peerLow <= !f[i];
      repeat (BIT) @(posedge clk_sys);
    end
  endtask

  // Mid-bit sampling, so clock skew between the two sides does not matter
  always begin
    @(negedge txLine);
    if (!syncMode) begin
      repeat (BIT / 2) @(posedge clk_sys);
      for (int i = 0; i < 10; i++) begin
        bits[i] = txLine;
        if (i < 9) repeat (BIT) @(posedge clk_sys);
      end
      if (bits[9]) begin
        report({4'h0, bits[8:1]});
      end else begin
        // Low stop bit: count every low bit time of the break
        n = 10;
        forever begin
          repeat (BIT) @(posedge clk_sys);
          if (txLine) break;
          n++;
        end
        report({4'h1, 8'(n)});
      end
    end
  end

  // Sync client: sample on the trailing edge, the return to idle level
  always @(posedge clk_sys) begin
    if (syncMode && prevClk !== txLine && txLine === polarity) begin
      shiftIn = {dataLine, shiftIn[7:1]};
      syncBits++;
      if (syncBits == 8) begin
        syncBits = 0;
        report({4'h2, shiftIn});
      end
    end
    prevClk = txLine;
  end
endmodule

// >>> dv/test_usart_break_wake_sync_host_tx.sv
// Self-checking bench for the break, wake and synchronous host serial port
`timescale 1ns/100ps
module test_usart_break_wake_sync_host_tx;
  logic clk_sys;
  logic rst_n;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWrite;
  logic regRead;
  logic [7:0] regRdData;
  logic rxDataOut;
  logic rxDataOe;
  logic serialClockOut;
  logic serialClockOe;
  logic peerLow;
  logic peerToggle;
  logic [11:0] peerValue;
  int peerBits;
  // Peer clocks data in only while the host drives the data pin
  wire peerSync = rxDataOe;
  logic peerPol;
  logic syncChk;
  logic seenToggle = 1'b0;
  logic rdSeen = 1'b0;
  logic prevClkT;
  logic prevData;
  logic [15:0] rdEntry;
  logic [15:0] rdQ[$];
  logic [11:0] lnkQ[$];
  logic [7:0] b1;
  logic [7:0] b2;
  int leads;
  int failCount = 0;
  int checksDone = 0;
  wire dataLine = rxDataOe ? rxDataOut : !peerLow;
  wire txLine = serialClockOe ? serialClockOut : 1'b1;

  sbw_core u_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdData(regRdData),
    .rxDataIn(dataLine),
    .rxDataOut(rxDataOut),
    .rxDataOe(rxDataOe),
    .serialClockOut(serialClockOut),
    .serialClockOe(serialClockOe)
  );

  sbw_peer #(.BIT(8)) u_peer (
    .clk_sys(clk_sys),
    .dataLine(dataLine),
    .txLine(txLine),
    .syncMode(peerSync),
    .polarity(peerPol),
    .peerLow(peerLow),
    .gotToggle(peerToggle),
    .gotValue(peerValue),
    .syncBits(peerBits)
  );

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    rdQ.push_back({m, e & m});
    @(posedge clk_sys);
    regRead <= 1'b0;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic drain();
    for (int i = 0; i < 3000 && lnkQ.size() != 0; i++) @(posedge clk_sys);
    if (lnkQ.size() != 0) check("frames pending", 12'h000, 12'(lnkQ.size()));
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rdSeen) begin
      rdEntry = rdQ.pop_front();
      check("read data", {4'h0, rdEntry[7:0]}, {4'h0, regRdData & rdEntry[15:8]});
    end
    rdSeen <= regRead;
  end

  always @(negedge clk_sys) begin
    if (peerToggle !== seenToggle) begin
      seenToggle = peerToggle;
      if (lnkQ.size() == 0) check("unexpected frame", 12'hfff, peerValue);
      else check("link frame", lnkQ.pop_front(), peerValue);
    end
    if (syncChk && prevClkT !== peerPol && dataLine !== prevData)
      check("data while clock active", 12'(prevData), 12'(dataLine));
    if (syncChk && prevClkT === peerPol && txLine !== peerPol) leads++;
    prevClkT = txLine;
    prevData = dataLine;
  end

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    failCount++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    peerPol = 1'b1;
    syncChk = 1'b0;
    void'($urandom(32'h42a3));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(sbw_pkg::REG_CTRL, 8'hff, 8'h00);
    rd(sbw_pkg::REG_MODE, 8'hff, 8'h00);
    rd(sbw_pkg::REG_STATUS, 8'h0f, 8'h03);
    rd(sbw_pkg::REG_TXDATA, 8'hff, 8'h00);
    rd(8'($urandom_range(8'hff, 8'h07)), 8'hff, 8'h00);
    // Async transmit, second byte queued behind the first, third refused
    wr(sbw_pkg::REG_BAUD_LO, 8'h07);
    wr(sbw_pkg::REG_BAUD_HI, 8'h00);
    wr(sbw_pkg::REG_CTRL, 8'h09);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    lnkQ.push_back({4'h0, b1});
    lnkQ.push_back({4'h0, b2});
    wr(sbw_pkg::REG_TXDATA, b1);
    wr(sbw_pkg::REG_TXDATA, b2);
    wr(sbw_pkg::REG_TXDATA, 8'($urandom));
    drain();
    waitc(12);
    rd(sbw_pkg::REG_STATUS, 8'h03, 8'h03);
    // Break header with queued async byte 55h
    wr(sbw_pkg::REG_CTRL, 8'h19);
    lnkQ.push_back(12'h10d);
    lnkQ.push_back(12'h055);
    wr(sbw_pkg::REG_TXDATA, 8'($urandom));
    waitc(2);
    rd(sbw_pkg::REG_STATUS, 8'h03, 8'h02);
    rd(sbw_pkg::REG_CTRL, 8'hff, 8'h19);
    wr(sbw_pkg::REG_TXDATA, 8'h55);
    drain();
    rd(sbw_pkg::REG_CTRL, 8'hff, 8'h09);
    // Receive a byte, then a break
    wr(sbw_pkg::REG_CTRL, 8'h49);
    b1 = 8'($urandom);
    u_peer.send_byte(b1);
    waitc(16);
    rd(sbw_pkg::REG_STATUS, 8'h0c, 8'h04);
    rd(sbw_pkg::REG_RXDATA, 8'hff, b1);
    rd(sbw_pkg::REG_STATUS, 8'h04, 8'h00);
    u_peer.drive(1'b1);
    waitc(13 * 8);
    u_peer.drive(1'b0);
    waitc(16);
    rd(sbw_pkg::REG_STATUS, 8'h0c, 8'h0c);
    rd(sbw_pkg::REG_RXDATA, 8'hff, 8'h00);
    // Wake on edge
    rd(sbw_pkg::REG_STATUS, 8'h10, 8'h10);
    wr(sbw_pkg::REG_MODE, 8'h02);
    u_peer.drive(1'b1);
    waitc(20);
    rd(sbw_pkg::REG_STATUS, 8'h04, 8'h04);
    rd(sbw_pkg::REG_MODE, 8'hff, 8'h02);
    u_peer.drive(1'b0);
    waitc(20);
    rd(sbw_pkg::REG_MODE, 8'hff, 8'h00);
    rd(sbw_pkg::REG_RXDATA, 8'h00, 8'h00);
    rd(sbw_pkg::REG_STATUS, 8'h04, 8'h00);
    b1 = 8'($urandom);
    u_peer.send_byte(b1);
    waitc(16);
    rd(sbw_pkg::REG_STATUS, 8'h04, 8'h04);
    rd(sbw_pkg::REG_RXDATA, 8'hff, b1);
    // Sync host transmit; idle-high polarity first keeps the pin still
    wr(sbw_pkg::REG_BAUD_LO, 8'h03);
    wr(sbw_pkg::REG_MODE, 8'h01);
    wr(sbw_pkg::REG_CTRL, 8'h0f);
    waitc(4);
    for (int p = 1; p >= 0; p--) begin
      wr(sbw_pkg::REG_MODE, 8'(p));
      waitc(4);
      peerPol <= p[0];
      syncChk <= 1'b1;
      leads = 0;
      b1 = 8'($urandom);
      lnkQ.push_back({4'h2, b1});
      wr(sbw_pkg::REG_TXDATA, b1);
      drain();
      waitc(8);
      check("leading edges", 12'h008, 12'(leads));
      check("partial bits", 12'h000, 12'(peerBits));
      check("clock idle", 12'(p[0]), 12'(serialClockOut));
      check("pin enables", 12'h003, {10'h000, rxDataOe, serialClockOe});
      syncChk <= 1'b0;
    end
    // Receive enable set in sync host: no transmission
    wr(sbw_pkg::REG_CTRL, 8'h2f);
    waitc(2);
    leads = 0;
    syncChk <= 1'b1;
    wr(sbw_pkg::REG_TXDATA, 8'($urandom));
    waitc(60);
    check("leading edges", 12'h000, 12'(leads));
    check("pin enables", 12'h001, {10'h000, rxDataOe, serialClockOe});
    conclude();
  end
endmodule
